/* rtl/ohr_pkg.sv */
// package: constants, types and command codes of the header/response config block
// Operation
// - summary lists number, colon, value, N/F
// - responses off: no wait, silent success
// - responses off overrides count; on at reset
// - receive address filters; auto mode unfilters
// - J1939 addresses come from header bytes
// - extended addressing uses separate target address
// - one nonvolatile user byte, store and read
// - remote frame: zero data, RTR set
// - remote frame only with active CAN
// - after remote frame wait unless responses off
// - auto-format hides received remote frames
// - voltage scaled 5.7 or 11 by supply
// - spaces between hex bytes when enabled
// - three-digit header keeps low 11 bits
// - header bytes priority, target, source
// - headers persist until overwritten or reset
// - assigned headers return after search defaults
// - CAN ID from headers plus priority bits
// - KWP protocols 4 and 5 insert length
// - KWP nonzero low digit: length in byte
// - KWP zero low digit: separate length byte
// - four-byte header sets whole 29-bit ID
package ohr_pkg;
  // register byte addresses
  localparam logic [7:0] OHR_CTRL_ADDR = 8'h00;
  localparam logic [7:0] OHR_HDR_ADDR = 8'h04;
  localparam logic [7:0] OHR_ADDR_ADDR = 8'h08;
  localparam logic [7:0] OHR_CMD_ADDR = 8'h0c;
  localparam logic [7:0] OHR_STAT_ADDR = 8'h10;
  localparam logic [7:0] OHR_VOLT_ADDR = 8'h14;
  localparam logic [7:0] OHR_TXID_ADDR = 8'h18;
  localparam logic [7:0] OHR_FMT_ADDR = 8'h1c;
  localparam logic [7:0] OHR_PP_ADDR = 8'h20;
  // control bit positions
  localparam int OHR_CTL_RESP = 0;
  localparam int OHR_CTL_SPACE = 1;
  localparam int OHR_CTL_CAF = 2;
  localparam int OHR_CTL_HDRSHOW = 3;
  localparam int OHR_CTL_CANACT = 4;
  localparam int OHR_CTL_AUTOSRCH = 5;
  localparam int OHR_CTL_HIVDD = 6;
  localparam logic [6:0] OHR_CTL_RESET = 7'h03;
  // command codes written to the command register
  localparam logic [3:0] OHR_CMD_SH3 = 4'h1;
  localparam logic [3:0] OHR_CMD_SH6 = 4'h2;
  localparam logic [3:0] OHR_CMD_SH8 = 4'h3;
  localparam logic [3:0] OHR_CMD_RXSET = 4'h4;
  localparam logic [3:0] OHR_CMD_RXAUTO = 4'h5;
  localparam logic [3:0] OHR_CMD_STORE = 4'h6;
  localparam logic [3:0] OHR_CMD_RTR = 4'h7;
  localparam logic [3:0] OHR_CMD_DEFLT = 4'h8;
  localparam logic [3:0] OHR_CMD_SEND = 4'h9;
  localparam logic [3:0] OHR_CMD_VOLT = 4'ha;
  localparam logic [3:0] OHR_CMD_PPSUM = 4'hb;
  localparam logic [3:0] OHR_CMD_FOUND = 4'hc;
  localparam logic [3:0] OHR_CMD_PRIO = 4'hd;
  // default header bytes and targets
  localparam logic [23:0] OHR_HDR_DEFAULT = 24'h686af1;
  localparam logic [4:0] OHR_PRIO_DEFAULT = 5'h18;
  localparam logic [7:0] OHR_TA_DEFAULT = 8'hf1;
  localparam logic [10:0] OHR_ID11_MASK = 11'h7ff;
  localparam logic [3:0] OHR_KWP_LOW_ZERO = 4'h0;
  localparam logic [3:0] OHR_PROTO_KWP_SLOW = 4'h4;
  localparam logic [3:0] OHR_PROTO_KWP_FAST = 4'h5;
  localparam logic [3:0] OHR_PROTO_J1939 = 4'ha;
  localparam int OHR_PP_COUNT = 48;
  // voltage scale in millivolts per code (10-bit adc, full scale 5 V)
  localparam logic [15:0] OHR_VSCALE_HI = 16'h001c;
  localparam logic [15:0] OHR_VSCALE_LO = 16'h0036;
  // status code values
  localparam logic [1:0] OHR_ST_OK = 2'h0;
  localparam logic [1:0] OHR_ST_FAIL = 2'h1;
  localparam logic [1:0] OHR_ST_WAIT = 2'h2;
  // ahb
  localparam logic [1:0] OHR_HTRANS_NONSEQ = 2'h2;
  // outgoing frame descriptor
  typedef struct packed {
    logic valid;
    logic rtr;
    logic [28:0] canId;
    logic [23:0] hdr;
    logic lenInFirst;
    logic lenExtra;
    logic waitReply;
  } ohr_frame_s;
  // bus-state machine
  typedef enum logic [1:0] {OHR_IDLE, OHR_BUSY, OHR_WAIT} ohr_state_e;
endpackage

/* rtl/ohr_header_response_config.sv */
// obd header, response and formatting configuration block with ahb-lite slave
//
// Chosen here: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module ohr_header_response_config (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [9:0] voltSample,
  input wire logic [3:0] protocolNum,
  input wire logic replyDone,
  input wire logic replyFail,
  input wire logic rxIsRemote,
  input wire logic [7:0] rxTarget,
  output ohr_pkg::ohr_frame_s frameOut,
  output logic rxShow,
  output logic [7:0] rxFilterAddr,
  output logic rxFilterOn,
  output logic [7:0] j1939RxAddr,
  output logic [7:0] extAddrDest
);
  import ohr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // functions
  // canId29 is shared by the frame builder and the read mux, so both see one id layout
  // the kwp choice keys only on the low digit of the first header byte
  // kwp length style: nonzero low digit puts the count in byte one
  function automatic logic kwpLenInFirst(input logic [7:0] b);
    kwpLenInFirst = (b[3:0] != OHR_KWP_LOW_ZERO);
  endfunction
  // 29-bit can id from priority bits and header bytes
  function automatic logic [28:0] canId29(input logic [4:0] p, input logic [23:0] h);
    canId29 = {p, h};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus address phase capture
  logic wrPend_reg; // write data phase pending
  logic [7:0] addrHold_reg; // latched address
  logic busWr; // write data phase strobe
  wire logic addrTaken = hsel && hready && (htrans == OHR_HTRANS_NONSEQ);
  assign busWr = wrPend_reg;

  // hreadyout never drops, so every address phase is answered next cycle
  // write data lands one edge after its address, as the bus requires
  // latch address phase
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      wrPend_reg <= 1'b0;
      addrHold_reg <= 8'h00;
    end
    else
    begin
      wrPend_reg <= addrTaken && hwrite;
      if (addrTaken)
        addrHold_reg <= haddr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration state
  // mode, header and address settings are plain registers written from the bus; search flag, state and status follow replies
  // command codes act in the write data phase of the command address
  logic [6:0] ctrl_reg; // mode bits
  logic [23:0] hdr_reg; // assigned header bytes
  logic [4:0] prio_reg; // can priority bits
  logic [7:0] rxAddr_reg; // manual receive address
  logic rxManual_reg; // receive filter active
  logic [7:0] ta_reg; // extended addressing target
  logic [7:0] nvByte_reg; // user byte store
  logic [23:0] argIn_reg; // command argument
  logic hdrSetEarly_reg; // headers set before protocol found
  logic searching_reg; // search using defaults
  logic [1:0] status_reg; // last command outcome
  logic [15:0] volt_reg; // millivolts
  logic [5:0] ppIdx_reg; // summary cursor
  logic [47:0] ppOn_reg; // parameter enable flags
  ohr_state_e state_reg; // send state
  wire logic cmdWr = busWr && (addrHold_reg == OHR_CMD_ADDR);
  wire logic [3:0] cmdCode = hwdata[3:0];

  // bit order follows the control map constants in the package
  // software sees the reset value until its first control write
  // control register; responses and spaces on after reset
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      ctrl_reg <= OHR_CTL_RESET;
    else if (busWr && addrHold_reg == OHR_CTRL_ADDR)
      ctrl_reg <= hwdata[6:0];
  end

  // argument must be written before the command that consumes it
  // held across commands, so a repeated command reuses the old argument
  // argument register
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      argIn_reg <= 24'h000000;
    else if (busWr && addrHold_reg == OHR_HDR_ADDR)
      argIn_reg <= hwdata[23:0];
  end

  // sh3 keeps eleven bits only; sh8 also loads the priority from the
  // command word itself; defaults restore both and forget early headers
  // a header set by sh3 or sh6 while no can protocol is active is marked early
  // header and priority assignment
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      hdr_reg <= OHR_HDR_DEFAULT;
      prio_reg <= OHR_PRIO_DEFAULT;
      hdrSetEarly_reg <= 1'b0;
    end
    else if (cmdWr)
    begin
      unique case (cmdCode)
        OHR_CMD_SH3:
        begin
          hdr_reg <= {13'h0000, argIn_reg[10:0] & OHR_ID11_MASK};
          hdrSetEarly_reg <= !ctrl_reg[OHR_CTL_CANACT];
        end
        OHR_CMD_SH6:
        begin
          hdr_reg <= argIn_reg;
          hdrSetEarly_reg <= !ctrl_reg[OHR_CTL_CANACT];
        end
        OHR_CMD_SH8:
        begin
          prio_reg <= hwdata[12:8];
          hdr_reg <= argIn_reg;
        end
        OHR_CMD_PRIO: prio_reg <= argIn_reg[4:0];
        OHR_CMD_DEFLT:
        begin
          hdr_reg <= OHR_HDR_DEFAULT;
          prio_reg <= OHR_PRIO_DEFAULT;
          hdrSetEarly_reg <= 1'b0;
        end
        default: ;
      endcase
    end
  end

  // the target write and the address commands never share a cycle, so
  // the if-chain order only documents priority
  // auto mode clears the filter but keeps the last address for readback
  // receive address filter and extended target
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rxAddr_reg <= 8'h00;
      rxManual_reg <= 1'b0;
      ta_reg <= OHR_TA_DEFAULT;
    end
    else if (busWr && addrHold_reg == OHR_ADDR_ADDR)
      ta_reg <= hwdata[15:8];
    else if (cmdWr && cmdCode == OHR_CMD_RXSET)
    begin
      rxAddr_reg <= argIn_reg[7:0];
      rxManual_reg <= 1'b1;
    end
    else if (cmdWr && (cmdCode == OHR_CMD_RXAUTO || cmdCode == OHR_CMD_DEFLT))
      rxManual_reg <= 1'b0;
  end

  // hazard: reads before the first store return an undefined byte
  // no reset branch on purpose, the byte must survive a reset
  // nonvolatile user byte, not cleared by reset
  always_ff @(posedge clk_sys)
  begin
    if (cmdWr && cmdCode == OHR_CMD_STORE)
      nvByte_reg <= argIn_reg[7:0];
  end

  // write {index, enable}; indices past the last parameter are dropped
  // flags clear at reset, so every parameter starts disabled
  // parameter enable flags
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      ppOn_reg <= 48'h000000000000;
    else if (busWr && addrHold_reg == OHR_PP_ADDR)
      ppOn_reg[hwdata[13:8]] <= hwdata[0];
  end

  // each read of the summary word returns one entry and steps on, except a read issued during a write data phase
  // after the last entry the cursor wraps to the first
  // summary cursor steps through every parameter
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      ppIdx_reg <= 6'h00;
    else if (cmdWr && cmdCode == OHR_CMD_PPSUM)
      ppIdx_reg <= 6'h00;
    else if (!busWr && addrTaken && !hwrite && haddr == OHR_PP_ADDR)
      ppIdx_reg <= (ppIdx_reg == 6'(OHR_PP_COUNT - 1)) ? 6'h00 : ppIdx_reg + 6'h01;
  end

  // scale factors fold the divider ratio and adc step into one product
  // limitation: the supply range comes from a control bit, not a comparator
  // the sample is taken when the command lands, later codes are ignored
  // voltage conversion by supply divider
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      volt_reg <= 16'h0000;
    else if (cmdWr && cmdCode == OHR_CMD_VOLT)
      volt_reg <= 16'(voltSample * (ctrl_reg[OHR_CTL_HIVDD] ? OHR_VSCALE_HI
                                                           : OHR_VSCALE_LO));
  end

  ////////////////////////////////////////////////////////////////////////////
  // send sequencing
  // one request in flight; send commands while busy are ignored
  // a refused remote frame sets the status and the descriptor fields, but no valid pulse leaves
  wire logic isKwp = (protocolNum == OHR_PROTO_KWP_SLOW) || (protocolNum == OHR_PROTO_KWP_FAST);
  wire logic sendReq = cmdWr && (cmdCode == OHR_CMD_SEND || cmdCode == OHR_CMD_RTR);
  wire logic rtrBad = cmdWr && cmdCode == OHR_CMD_RTR && !ctrl_reg[OHR_CTL_CANACT];
  // default headers while a search runs with early headers
  wire logic [23:0] hdrUse = searching_reg ? OHR_HDR_DEFAULT : hdr_reg;

  // a failed reply sets the flag even when found lands in the same
  // cycle, so the fallback to default headers is never lost
  // search fallback flag
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      searching_reg <= 1'b0;
    else if (state_reg == OHR_WAIT && replyFail && hdrSetEarly_reg && ctrl_reg[OHR_CTL_AUTOSRCH])
      searching_reg <= 1'b1;
    else if (cmdWr && cmdCode == OHR_CMD_FOUND)
      searching_reg <= 1'b0;
  end

  // busy lasts one cycle so the frame descriptor is out before the wait
  // with responses off the request ends at once and reports success
  // in wait a failure pulse wins over a done pulse in the same cycle
  // state and status
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_reg <= OHR_IDLE;
      status_reg <= OHR_ST_OK;
    end
    else
    begin
      unique case (state_reg)
        OHR_IDLE:
          if (rtrBad)
            status_reg <= OHR_ST_FAIL;
          else if (sendReq)
          begin
            state_reg <= OHR_BUSY;
            status_reg <= OHR_ST_WAIT;
          end
        OHR_BUSY:
          if (ctrl_reg[OHR_CTL_RESP])
            state_reg <= OHR_WAIT;
          else
          begin
            state_reg <= OHR_IDLE;
            status_reg <= OHR_ST_OK;
          end
        OHR_WAIT:
          if (replyFail)
          begin
            state_reg <= OHR_IDLE;
            status_reg <= OHR_ST_FAIL;
          end
          else if (replyDone)
          begin
            state_reg <= OHR_IDLE;
            status_reg <= OHR_ST_OK;
          end
      endcase
    end
  end

  // valid is a one-cycle pulse; the other fields hold until the next
  // request, so the far side may read them late
  // frame descriptor out
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      frameOut <= '0;
    else
    begin
      frameOut.valid <= (state_reg == OHR_IDLE) && sendReq && !rtrBad;
      if ((state_reg == OHR_IDLE) && sendReq)
      begin
        frameOut.rtr <= (cmdCode == OHR_CMD_RTR);
        frameOut.canId <= canId29(prio_reg, hdrUse);
        frameOut.hdr <= hdrUse;
        frameOut.lenInFirst <= isKwp && kwpLenInFirst(hdrUse[23:16]);
        frameOut.lenExtra <= isKwp && !kwpLenInFirst(hdrUse[23:16]);
        frameOut.waitReply <= ctrl_reg[OHR_CTL_RESP];
      end
    end
  end

  // all receive-side controls are registered, one cycle behind inputs
  // j1939 takes its own address from the header source byte, never from
  // the manual receive address; a broadcast target is never filtered
  // receive side outputs
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rxShow <= 1'b1;
      rxFilterAddr <= 8'h00;
      rxFilterOn <= 1'b0;
      j1939RxAddr <= 8'h00;
      extAddrDest <= OHR_TA_DEFAULT;
    end
    else
    begin
      rxShow <= !rxIsRemote || !ctrl_reg[OHR_CTL_CAF] || ctrl_reg[OHR_CTL_HDRSHOW];
      rxFilterAddr <= rxAddr_reg;
      rxFilterOn <= rxManual_reg && (protocolNum != OHR_PROTO_J1939) && (rxTarget != 8'hff);
      j1939RxAddr <= hdr_reg[7:0];
      extAddrDest <= ta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data is registered at the address phase and stands in the
  // data phase; unmapped offsets read as zero
  // read mux
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      hrdata <= 32'h00000000;
    else if (addrTaken && !hwrite)
    begin
      unique case (haddr)
        OHR_CTRL_ADDR: hrdata <= {25'h0000000, ctrl_reg};
        OHR_HDR_ADDR: hrdata <= {3'h0, prio_reg, hdr_reg};
        OHR_ADDR_ADDR: hrdata <= {15'h0000, rxManual_reg, ta_reg, rxAddr_reg};
        OHR_CMD_ADDR: hrdata <= {24'h000000, nvByte_reg};
        OHR_STAT_ADDR: hrdata <= {28'h0000000, state_reg, status_reg};
        OHR_VOLT_ADDR: hrdata <= {16'h0000, volt_reg};
        OHR_TXID_ADDR: hrdata <= {3'h0, canId29(prio_reg, hdrUse)};
        OHR_FMT_ADDR: hrdata <= {31'h00000000, ctrl_reg[OHR_CTL_SPACE]};
        OHR_PP_ADDR: hrdata <= {16'h0000, 2'h0, ppIdx_reg, 7'h00, ppOn_reg[ppIdx_reg]};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // no wait states and never an error response
  // kept as registers so the outputs come from flip-flops
  // zero-wait okay slave
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* tb/ohr_bus_model.sv */
// vehicle bus side model: answers each frame that waits for a reply
`timescale 1ns/1ps
`default_nettype none
module ohr_bus_model
  import ohr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire ohr_pkg::ohr_frame_s frameOut,
  input wire logic slow,
  input wire logic fail,
  output logic replyDone,
  output logic replyFail
);
  int cnt; // cycles left before the reply
  // reply pulse after a short or a long delay
  always_ff @(posedge clk_sys)
  begin
    replyDone <= 1'b0;
    replyFail <= 1'b0;
    if (rst)
      cnt <= 0;
    else if (frameOut.valid && frameOut.waitReply)
      cnt <= slow ? 40 : 2;
    else if (cnt == 1)
    begin
      replyDone <= !fail;
      replyFail <= fail;
      cnt <= 0;
    end
    else if (cnt > 1)
      cnt <= cnt - 1;
  end
endmodule
`default_nettype wire

/* tb/ohr_chk.sv */
// checker of port relations of the header and response block
`timescale 1ns/1ps
`default_nettype none
module ohr_chk
  import ohr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [3:0] protocolNum,
  input wire logic rxIsRemote,
  input wire ohr_pkg::ohr_frame_s frameOut,
  input wire logic rxShow,
  input wire logic rxFilterOn
);
  logic pend; // write data phase pending
  logic [7:0] padr;
  logic [6:0] ctl; // shadow of control register
  // follow control writes on the bus
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pend <= 1'b0;
      ctl <= OHR_CTL_RESET;
    end
    else
    begin
      pend <= hsel && hready && htrans == OHR_HTRANS_NONSEQ && hwrite;
      padr <= haddr;
      if (pend && padr == OHR_CTRL_ADDR)
        ctl <= hwdata[6:0];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  bus_ok_a: assert property (hreadyout && !hresp)
    else $error("bus stalled or error");
  wait_flag_a: assert property (frameOut.valid |-> frameOut.waitReply == ctl[OHR_CTL_RESP])
    else $error("reply wait flag wrong");
  rtr_active_a: assert property (frameOut.valid && frameOut.rtr |-> ctl[OHR_CTL_CANACT])
    else $error("remote frame without can");
  frame_pulse_a: assert property (frameOut.valid |=> !frameOut.valid)
    else $error("frame valid too long");
  remote_hide_a: assert property (1'b1 |=> rxShow == !($past(rxIsRemote)
    && $past(ctl[OHR_CTL_CAF]) && !$past(ctl[OHR_CTL_HDRSHOW])))
    else $error("remote display wrong");
  kwp_len_a: assert property (frameOut.valid && (protocolNum == 4'h4 || protocolNum == 4'h5)
    |-> frameOut.lenInFirst == (frameOut.hdr[19:16] != 4'h0)
    && frameOut.lenExtra == (frameOut.hdr[19:16] == 4'h0))
    else $error("length placement wrong");
  can_id_a: assert property (frameOut.valid && (protocolNum == 4'h7 || protocolNum == 4'h9)
    |-> frameOut.canId[23:0] == frameOut.hdr)
    else $error("can id low bytes wrong");
  j1939_free_a: assert property (protocolNum == OHR_PROTO_J1939 |=> !rxFilterOn)
    else $error("filter under j1939");
  cover property (frameOut.valid && frameOut.rtr);
  cover property (frameOut.valid && !frameOut.waitReply);
  cover property (!rxShow);
endmodule
bind ohr_header_response_config ohr_chk ohr_chk_inst (.clk_sys(clk_sys), .rst(rst),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .protocolNum(protocolNum),
  .rxIsRemote(rxIsRemote), .frameOut(frameOut), .rxShow(rxShow), .rxFilterOn(rxFilterOn));
`default_nettype wire

/* tb/tb_ohr_header_response_config.sv */
// self-checking bench of the header and response block
`timescale 1ns/1ps
`default_nettype none
module tb_ohr_header_response_config;
  import ohr_pkg::*;
  logic clk_sys = 0, rst = 1, hsel = 0, hwrite = 0, rxIsRemote = 0, slow = 0, fail = 0;
  logic [47:0] ppM; // model parameter enable flags
  logic [7:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic [31:0] hwdata = 0, hrdata, r, a;
  logic [9:0] voltSample = 0;
  logic [3:0] protocolNum = 4'h7;
  logic hreadyout, hresp, replyDone, replyFail, rxShow, rxFilterOn;
  logic [7:0] rxFilterAddr, j1939RxAddr, extAddrDest;
  wire logic hready;
  ohr_frame_s frameOut, lastF = '0;
  int fail_count = 0, total_checks = 0, seed = 59;
  logic [23:0] hdrM; // model header bytes
  logic [4:0] prioM; // model priority bits
  assign hready = hreadyout;
  ohr_header_response_config ohr_header_response_config_inst (.clk_sys(clk_sys), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .voltSample(voltSample), .protocolNum(protocolNum), .replyDone(replyDone),
    .replyFail(replyFail), .rxIsRemote(rxIsRemote), .rxTarget(8'h10), .frameOut(frameOut),
    .rxShow(rxShow), .rxFilterAddr(rxFilterAddr), .rxFilterOn(rxFilterOn),
    .j1939RxAddr(j1939RxAddr), .extAddrDest(extAddrDest));
  ohr_bus_model ohr_bus_model_inst (.clk_sys(clk_sys), .rst(rst), .frameOut(frameOut),
    .slow(slow), .fail(fail), .replyDone(replyDone), .replyFail(replyFail));
  initial forever #2.5 clk_sys = ~clk_sys;
  // keep the last frame sent
  always @(posedge clk_sys) if (frameOut.valid === 1'b1) lastF <= frameOut;
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // bounded wait for hready at a rising edge
  task automatic hwait();
    int n;
    n = 0;
    @(posedge clk_sys);
    while (hready !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        fail_count++;
        final_report();
      end
      @(posedge clk_sys);
    end
  endtask
  // one ahb-lite single word transfer, read data into r
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= ad;
    htrans <= OHR_HTRANS_NONSEQ;
    hwrite <= w;
    hwait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hwait();
    r = hrdata;
  endtask
  // argument then command code
  task automatic cmd(input logic [3:0] c, input logic [31:0] arg);
    bus(1, OHR_HDR_ADDR, arg);
    bus(1, OHR_CMD_ADDR, {28'h0, c});
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic hdrchk();
    bus(0, OHR_HDR_ADDR, 0);
    chk(r, {3'h0, prioM, hdrM});
  endtask
  initial
  begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    prioM = OHR_PRIO_DEFAULT;
    hdrM = OHR_HDR_DEFAULT;
    bus(0, OHR_CTRL_ADDR, 0);
    chk(r, 32'h3);
    hdrchk();
    chk(32'(extAddrDest), 32'(OHR_TA_DEFAULT));
    cmd(OHR_CMD_SH3, 32'hfdf);
    hdrM = 24'h0007df;
    hdrchk();
    a = $random(seed);
    cmd(OHR_CMD_SH6, a);
    hdrM = a[23:0];
    hdrchk();
    bus(0, OHR_TXID_ADDR, 0);
    chk(r, {3'h0, prioM, hdrM});
    // four-byte header: priority rides in the command word
    a = $random(seed);
    bus(1, OHR_HDR_ADDR, a);
    bus(1, OHR_CMD_ADDR, {19'h0, a[28:24], 4'h0, OHR_CMD_SH8});
    prioM = a[28:24];
    hdrM = a[23:0];
    hdrchk();
    cmd(OHR_CMD_PRIO, 32'h0b);
    prioM = 5'h0b;
    bus(0, OHR_TXID_ADDR, 0);
    chk(r, {3'h0, prioM, hdrM});
    chk(32'(j1939RxAddr), 32'(hdrM[7:0]));
    cmd(OHR_CMD_DEFLT, 0);
    hdrM = OHR_HDR_DEFAULT;
    prioM = OHR_PRIO_DEFAULT;
    hdrchk();
    a = $random(seed);
    cmd(OHR_CMD_STORE, a);
    bus(0, OHR_CMD_ADDR, 0);
    chk(32'(r[7:0]), 32'(a[7:0]));
    // remote frame refused, then sent with a slow reply
    cmd(OHR_CMD_RTR, 0);
    bus(0, OHR_STAT_ADDR, 0);
    chk(32'(r[1:0]), 32'(OHR_ST_FAIL));
    slow <= 1'b1;
    bus(1, OHR_CTRL_ADDR, 32'h13);
    cmd(OHR_CMD_RTR, 0);
    chk(32'(lastF.rtr), 32'h1);
    bus(0, OHR_STAT_ADDR, 0);
    chk(32'(r[3:2]), 32'(OHR_WAIT));
    repeat (50) @(posedge clk_sys);
    bus(0, OHR_STAT_ADDR, 0);
    chk(32'(r[3:0]), 32'h0);
    bus(1, OHR_CTRL_ADDR, 32'h12);
    cmd(OHR_CMD_SEND, 0);
    chk(32'(lastF.waitReply), 32'h0);
    bus(0, OHR_STAT_ADDR, 0);
    chk(32'(r[3:0]), 32'h0);
    rxIsRemote <= 1'b1;
    bus(1, OHR_CTRL_ADDR, 32'h07);
    repeat (2) @(posedge clk_sys);
    chk(32'(rxShow), 32'h0);
    bus(1, OHR_CTRL_ADDR, 32'h0f);
    repeat (2) @(posedge clk_sys);
    chk(32'(rxShow), 32'h1);
    rxIsRemote <= 1'b0;
    cmd(OHR_CMD_RXSET, 32'h3a);
    chk(32'(rxFilterOn), 32'h1);
    chk(32'(rxFilterAddr), 32'h3a);
    protocolNum <= OHR_PROTO_J1939;
    repeat (2) @(posedge clk_sys);
    chk(32'(rxFilterOn), 32'h0);
    protocolNum <= 4'h7;
    cmd(OHR_CMD_RXAUTO, 0);
    chk(32'(rxFilterOn), 32'h0);
    a = $random(seed);
    bus(1, OHR_ADDR_ADDR, {16'h0, a[7:0], 8'h0});
    repeat (2) @(posedge clk_sys);
    chk(32'(extAddrDest), 32'(a[7:0]));
    // voltage for both supply ranges
    for (int i = 0; i < 2; i++)
    begin
      voltSample <= 10'($random(seed));
      bus(1, OHR_CTRL_ADDR, i ? 32'h43 : 32'h03);
      cmd(OHR_CMD_VOLT, 0);
      bus(0, OHR_VOLT_ADDR, 0);
      chk(r, 32'(voltSample) * (i ? 32'd28 : 32'd54));
    end
    bus(1, OHR_CTRL_ADDR, 32'h01);
    bus(0, OHR_FMT_ADDR, 0);
    chk(32'(r[0]), 32'h0);
    bus(1, OHR_CTRL_ADDR, 32'h03);
    bus(0, OHR_FMT_ADDR, 0);
    chk(32'(r[0]), 32'h1);
    // kwp length placement, both protocols and both first bytes
    slow <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      protocolNum <= i[0] ? OHR_PROTO_KWP_FAST : OHR_PROTO_KWP_SLOW;
      cmd(OHR_CMD_SH6, i[1] ? 32'h816af1 : 32'h806af1);
      cmd(OHR_CMD_SEND, 0);
      chk(32'(lastF.lenInFirst), 32'(i[1]));
      chk(32'(lastF.lenExtra), 32'(!i[1]));
      repeat (10) @(posedge clk_sys);
    end
    // parameter summary: random enables, then the cursor walks every entry
    for (int i = 0; i < OHR_PP_COUNT; i++)
    begin
      a = $random(seed);
      ppM[i] = a[0];
      bus(1, OHR_PP_ADDR, {18'h0, 6'(i), 7'h0, a[0]});
    end
    cmd(OHR_CMD_PPSUM, 0);
    for (int i = 0; i <= OHR_PP_COUNT; i++)
    begin
      bus(0, OHR_PP_ADDR, 0);
      chk(r, {18'h0, 6'(i % OHR_PP_COUNT), 7'h0, ppM[i % OHR_PP_COUNT]});
    end
    // failed first reply falls back to default headers until found
    fail <= 1'b1;
    bus(1, OHR_CTRL_ADDR, 32'h21);
    hdrM = 24'h123456;
    cmd(OHR_CMD_SH6, 32'h123456);
    cmd(OHR_CMD_SEND, 0);
    chk(32'(lastF.hdr), 32'(hdrM));
    repeat (5) @(posedge clk_sys);
    bus(0, OHR_STAT_ADDR, 0);
    chk(32'(r[1:0]), 32'(OHR_ST_FAIL));
    fail <= 1'b0;
    cmd(OHR_CMD_SEND, 0);
    chk(32'(lastF.hdr), 32'(OHR_HDR_DEFAULT));
    repeat (5) @(posedge clk_sys);
    cmd(OHR_CMD_FOUND, 0);
    bus(0, OHR_TXID_ADDR, 0);
    chk(r, {3'h0, prioM, hdrM});
    bus(1, 8'h40, 32'hffff);
    bus(0, 8'h40, 0);
    chk(r, 32'h0);
    final_report();
  end
  initial
  begin
    #400000;
    fail_count++;
    final_report();
  end
endmodule
`default_nettype wire
